// *** hw/can_irq_regs.svh ***
// Register offsets, field positions and reset values of the interrupt router.
`ifndef CAN_IRQ_REGS_SVH
`define CAN_IRQ_REGS_SVH

`define OFS_GLOBAL_MASK     12'h000
`define OFS_MBOX_MASK       12'h004
`define OFS_MBOX_LINE       12'h008
`define OFS_PROTECT         12'h00C
`define OFS_STATUS          12'h010
`define OFS_SOURCES         12'h014
`define OFS_PENDING         12'h018
`define OFS_LOST            12'h01C

`define BIT_TIMEOUT         17
`define BIT_STAMP_OVF       16
`define BIT_ABORT_ACK       14
`define BIT_WRITE_DENIED    13
`define BIT_WAKEUP          12
`define BIT_MSG_LOST        11
`define BIT_BUS_OFF         10
`define BIT_ERR_PASSIVE     9
`define BIT_WARN_LEVEL      8
`define BIT_GLOBAL_LINE     2
`define BIT_LINE1_EN        1
`define BIT_LINE0_EN        0

`define GLOBAL_MASK_WMASK   32'h0003_7F07
`define RESET_WORD          32'h0000_0000
`define STATUS_VEC_LSB      0
`define STATUS_VEC_MSB      4
`define STATUS_GLOBAL_MAILBOX_FLAG         5
`define STATUS_LINE0        6
`define STATUS_LINE1        7
`define STATUS_MASK         32'h0000_00FF
`define COMPAT_TOP          5'h0F
`define COMPAT_MASK         32'h0000_FFFF

`endif

// *** hw/can_irq_pkg.sv ***
// Types shared by the interrupt router files.
package can_irq_pkg;
	typedef enum logic [1:0] {
		rx_idle,
		rx_search,
		rx_finish
	} rx_state_e;
endpackage

// *** hw/can_rx_store.sv ***
// Receive placement: finds a free or overwritable mailbox for a new message.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_regs.svh"
module can_rx_store #(
	parameter int MBOXES = 32
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              rx_valid,
	input  wire logic [MBOXES-1:0] rx_match,
	input  wire logic [MBOXES-1:0] pending,
	input  wire logic [MBOXES-1:0] protect,
	output logic                   store_valid,
	output logic [4:0]             store_index,
	output logic                   store_overwrite,
	output logic                   dropped
);
	typedef struct packed {
		can_irq_pkg::rx_state_e st;
		logic                   store_valid;
		logic [4:0]             store_index;
		logic                   store_overwrite;
		logic                   dropped;
		logic [MBOXES-1:0]      cand;
		logic [MBOXES-1:0]      pend;
		logic [MBOXES-1:0]      prot;
	} state_s;

	state_s r;
	state_s next_r;

	// Candidates are scanned from mailbox 0 up; the highest-numbered usable one is kept.
	always_comb begin
		next_r = r;
		next_r.store_valid = 1'b0;
		next_r.dropped = 1'b0;
		case (r.st)
			can_irq_pkg::rx_idle: begin
				if (rx_valid) begin
					next_r.cand = rx_match;
					next_r.pend = pending;
					next_r.prot = protect;
					next_r.st = can_irq_pkg::rx_search;
				end
			end
			can_irq_pkg::rx_search: begin
				next_r.st = can_irq_pkg::rx_finish;
				next_r.dropped = 1'b1;
				for (int i = 0; i < MBOXES; i++) begin
					if (r.cand[i] && !(r.pend[i] && r.prot[i])) begin
						next_r.store_index = 5'(i);
						next_r.store_overwrite = r.pend[i];
						next_r.store_valid = 1'b1;
						next_r.dropped = 1'b0;
					end
				end
			end
			can_irq_pkg::rx_finish: begin
				next_r.st = can_irq_pkg::rx_idle;
			end
			default: begin
				next_r.st = can_irq_pkg::rx_idle;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign store_valid = r.store_valid;
	assign store_index = r.store_index;
	assign store_overwrite = r.store_overwrite;
	assign dropped = r.dropped;

	property p_protected_kept;
		@(posedge pclk) disable iff (!presetn)
		store_valid |-> !(r.pend[store_index] && r.prot[store_index]);
	endproperty
	a_protected_kept: assert property (p_protected_kept)
		else $error("protected mailbox was overwritten");

	property p_overwrite_flag;
		@(posedge pclk) disable iff (!presetn)
		store_valid |-> (store_overwrite == r.pend[store_index]);
	endproperty
	a_overwrite_flag: assert property (p_overwrite_flag)
		else $error("overwrite flag does not follow pending state");
endmodule // can_rx_store
`default_nettype wire

// *** hw/can_irq_router.sv ***
// Interrupt masking, line routing and receive overwrite policy of the CAN core.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_regs.svh"
module can_irq_router #(
	parameter int MBOXES = 32
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              protected_write_mode,
	input  wire logic              reduced_compat_mode,
	input  wire logic              timeout_event,
	input  wire logic              stamp_overflow_event,
	input  wire logic              abort_ack_event,
	input  wire logic              write_denied_event,
	input  wire logic              wakeup_event,
	input  wire logic              bus_off_event,
	input  wire logic              error_passive_event,
	input  wire logic              warning_level_event,
	input  wire logic [MBOXES-1:0] tx_done,
	input  wire logic              rx_valid,
	input  wire logic [MBOXES-1:0] rx_match,
	output logic                   rx_store_valid,
	output logic [4:0]             rx_store_index,
	output logic                   irq_line_zero,
	output logic                   irq_line_one
);
	typedef struct packed {
		logic [31:0]       gmask;
		logic [MBOXES-1:0] mbox_mask;
		logic [MBOXES-1:0] mbox_line;
		logic [MBOXES-1:0] protect;
		logic [31:0]       gflags;
		logic [MBOXES-1:0] mbox_flag;
		logic [MBOXES-1:0] receive_pending;
		logic [MBOXES-1:0] receive_lost;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              store_valid;
		logic [4:0]        store_index;
		logic              irq0;
		logic              irq1;
	} state_s;

	state_s r;
	state_s next_r;

	logic       sv_valid;
	logic [4:0] sv_index;
	logic       sv_over;

	can_rx_store #(
		.MBOXES(MBOXES)
	) i_can_rx_store (
		.pclk           (pclk),
		.presetn        (presetn),
		.rx_valid       (rx_valid),
		.rx_match       (rx_match),
		.pending        (r.receive_pending),
		.protect        (r.protect),
		.store_valid    (sv_valid),
		.store_index    (sv_index),
		.store_overwrite(sv_over),
		.dropped        ()
	);

	// Highest-numbered pending mailbox flag, limited in compat mode.
	function automatic logic [4:0] top_mailbox(input logic [MBOXES-1:0] f,
		input logic compat);
		logic [4:0] v;
		v = 5'h00;
		for (int i = 0; i < MBOXES; i++) begin
			if (f[i] && (!compat || 5'(i) <= `COMPAT_TOP)) begin
				v = 5'(i);
			end
		end
		return v;
	endfunction

	// Accesses that are answered with an error response.
	function automatic logic bad_access(input logic [11:0] a,
		input logic [3:0] s);
		logic bad;
		bad = 1'b0;
		case (a)
			`OFS_GLOBAL_MASK, `OFS_MBOX_MASK, `OFS_MBOX_LINE, `OFS_STATUS,
			`OFS_SOURCES, `OFS_PENDING, `OFS_LOST: bad = 1'b0;
			`OFS_PROTECT: bad = (s != 4'hF);
			default: bad = 1'b1;
		endcase
		return bad;
	endfunction

	logic        access;
	logic        wr;
	logic        full_word;
	logic [31:0] en_global;
	logic        any_global;
	logic [MBOXES-1:0] en_mbox;
	logic [4:0]  vector;
	logic        global_mailbox_flag;
	logic        line0_req;
	logic        line1_req;
	logic [MBOXES-1:0] rx_done;
	logic [MBOXES-1:0] pend_clr;

	always_comb begin
		access = psel && penable && !r.pready;
		// A write takes effect at the edge that completes the transfer.
		wr = psel && penable && pwrite && r.pready;
		full_word = (pstrb == 4'hF);
		next_r = r;
		next_r.pready = access;
		next_r.pslverr = access && bad_access(paddr, pstrb);
		next_r.prdata = `RESET_WORD;
		next_r.store_valid = sv_valid;
		next_r.store_index = sv_index;
		rx_done = '0;
		pend_clr = '0;
		if (sv_valid) begin
			rx_done[sv_index] = 1'b1;
		end
		// Software writes; pending clear is write one to clear.
		if (wr) begin
			case (paddr)
				`OFS_GLOBAL_MASK: begin
					if (protected_write_mode) begin
						next_r.gmask = pwdata & `GLOBAL_MASK_WMASK;
					end
				end
				`OFS_MBOX_MASK: begin
					if (protected_write_mode) begin
						next_r.mbox_mask = pwdata[MBOXES-1:0];
					end
				end
				`OFS_MBOX_LINE: next_r.mbox_line = pwdata[MBOXES-1:0];
				`OFS_PROTECT: begin
					if (full_word) begin
						next_r.protect = pwdata[MBOXES-1:0];
					end
				end
				`OFS_PENDING: pend_clr = pwdata[MBOXES-1:0];
				`OFS_LOST: next_r.receive_lost = r.receive_lost & ~pwdata[MBOXES-1:0];
				`OFS_SOURCES: next_r.gflags = r.gflags & ~pwdata;
				`OFS_STATUS: ;
				default: ;
			endcase
		end

		// Receive bookkeeping; hardware set wins over software clear.
		next_r.receive_pending = (r.receive_pending & ~pend_clr) | rx_done;
		if (sv_valid && sv_over) begin
			next_r.receive_lost[sv_index] = 1'b1;
		end
		next_r.receive_lost = next_r.receive_lost & next_r.receive_pending;
		next_r.mbox_flag = (r.mbox_flag & ~pend_clr) | tx_done | rx_done;

		// Global events are sticky; lost flag follows the lost bits.
		if (timeout_event) next_r.gflags[`BIT_TIMEOUT] = 1'b1;
		if (stamp_overflow_event) next_r.gflags[`BIT_STAMP_OVF] = 1'b1;
		if (abort_ack_event) next_r.gflags[`BIT_ABORT_ACK] = 1'b1;
		if (write_denied_event) next_r.gflags[`BIT_WRITE_DENIED] = 1'b1;
		if (wakeup_event) next_r.gflags[`BIT_WAKEUP] = 1'b1;
		if (bus_off_event) next_r.gflags[`BIT_BUS_OFF] = 1'b1;
		if (error_passive_event) next_r.gflags[`BIT_ERR_PASSIVE] = 1'b1;
		if (warning_level_event) next_r.gflags[`BIT_WARN_LEVEL] = 1'b1;
		next_r.gflags[`BIT_MSG_LOST] = |next_r.receive_lost;

		// Masking and routing from registered state.
		en_global = r.gflags & r.gmask;
		en_global[7:0] = 8'h00;
		any_global = |en_global;
		en_mbox = r.mbox_flag & r.mbox_mask;
		if (reduced_compat_mode) begin
			en_mbox = en_mbox & MBOXES'(`COMPAT_MASK);
		end
		global_mailbox_flag = |en_mbox;
		vector = top_mailbox(en_mbox, reduced_compat_mode);
		line0_req = (|(en_mbox & ~r.mbox_line))
			|| (any_global && !r.gmask[`BIT_GLOBAL_LINE]);
		line1_req = (|(en_mbox & r.mbox_line))
			|| (any_global && r.gmask[`BIT_GLOBAL_LINE]);
		next_r.irq0 = r.gmask[`BIT_LINE0_EN] && line0_req;
		next_r.irq1 = r.gmask[`BIT_LINE1_EN] && line1_req;

		if (access && !pwrite) begin
			case (paddr)
				`OFS_GLOBAL_MASK: next_r.prdata = r.gmask;
				`OFS_MBOX_MASK: next_r.prdata[MBOXES-1:0] = r.mbox_mask;
				`OFS_MBOX_LINE: next_r.prdata[MBOXES-1:0] = r.mbox_line;
				`OFS_PROTECT: begin
					if (full_word) begin
						next_r.prdata[MBOXES-1:0] = r.protect;
					end
				end
				`OFS_STATUS: begin
					next_r.prdata[`STATUS_VEC_MSB:`STATUS_VEC_LSB] = vector;
					next_r.prdata[`STATUS_GLOBAL_MAILBOX_FLAG] = global_mailbox_flag;
					next_r.prdata[`STATUS_LINE0] = r.irq0;
					next_r.prdata[`STATUS_LINE1] = r.irq1;
				end
				`OFS_SOURCES: next_r.prdata = r.gflags;
				`OFS_PENDING: next_r.prdata[MBOXES-1:0] = r.receive_pending;
				`OFS_LOST: next_r.prdata[MBOXES-1:0] = r.receive_lost;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign rx_store_valid = r.store_valid;
	assign rx_store_index = r.store_index;
	assign irq_line_zero = r.irq0;
	assign irq_line_one = r.irq1;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------

	property p_mask_locked;
		@(posedge pclk) disable iff (!presetn)
		(wr && !protected_write_mode && paddr == `OFS_GLOBAL_MASK)
		|=> $stable(r.gmask);
	endproperty
	a_mask_locked: assert property (p_mask_locked)
		else $error("global mask changed outside protected mode");

	property p_mbox_mask_locked;
		@(posedge pclk) disable iff (!presetn)
		(wr && !protected_write_mode && paddr == `OFS_MBOX_MASK)
		|=> $stable(r.mbox_mask);
	endproperty
	a_mbox_mask_locked: assert property (p_mbox_mask_locked)
		else $error("mailbox mask changed outside protected mode");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		(r.gmask & ~`GLOBAL_MASK_WMASK) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved global mask bit set");

	property p_line0_off;
		@(posedge pclk) disable iff (!presetn)
		!r.gmask[`BIT_LINE0_EN] |=> !irq_line_zero;
	endproperty
	a_line0_off: assert property (p_line0_off)
		else $error("line zero active while disabled");

	property p_line1_off;
		@(posedge pclk) disable iff (!presetn)
		!r.gmask[`BIT_LINE1_EN] |=> !irq_line_one;
	endproperty
	a_line1_off: assert property (p_line1_off)
		else $error("line one active while disabled");

	property p_global_route;
		@(posedge pclk) disable iff (!presetn)
		(any_global && r.gmask[`BIT_GLOBAL_LINE] && r.gmask[`BIT_LINE1_EN])
		|=> irq_line_one;
	endproperty
	a_global_route: assert property (p_global_route)
		else $error("global source not routed to line one");

	property p_mbox_route;
		@(posedge pclk) disable iff (!presetn)
		(|(en_mbox & ~r.mbox_line) && r.gmask[`BIT_LINE0_EN])
		|=> irq_line_zero;
	endproperty
	a_mbox_route: assert property (p_mbox_route)
		else $error("mailbox source not routed to line zero");

	property p_lost_set;
		@(posedge pclk) disable iff (!presetn)
		(sv_valid && sv_over) |=> r.receive_lost[$past(sv_index)];
	endproperty
	a_lost_set: assert property (p_lost_set)
		else $error("lost bit not set on overwrite");

	property p_lost_flag;
		@(posedge pclk) disable iff (!presetn)
		r.gflags[`BIT_MSG_LOST] == |r.receive_lost;
	endproperty
	a_lost_flag: assert property (p_lost_flag)
		else $error("message lost flag out of step");

	property p_global_route0;
		@(posedge pclk) disable iff (!presetn)
		(any_global && !r.gmask[`BIT_GLOBAL_LINE] && r.gmask[`BIT_LINE0_EN])
		|=> irq_line_zero;
	endproperty
	a_global_route0: assert property (p_global_route0)
		else $error("global source not routed to line zero");

	property p_mbox_route1;
		@(posedge pclk) disable iff (!presetn)
		(|(en_mbox & r.mbox_line) && r.gmask[`BIT_LINE1_EN])
		|=> irq_line_one;
	endproperty
	a_mbox_route1: assert property (p_mbox_route1)
		else $error("mailbox source not routed to line one");
endmodule // can_irq_router
`default_nettype wire

// *** verification/irq_sink.sv ***
// Model of the processor interrupt input stage fed by the two lines.
`timescale 1ns/1ps
`default_nettype none
module irq_sink (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       irq_line_zero,
	input  wire logic       irq_line_one,
	output logic      [1:0] seen
);
	// The lines are level inputs, sampled once per clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seen <= 2'b00;
		else
			seen <= {irq_line_one, irq_line_zero};
	end
endmodule // irq_sink
`default_nettype wire

// *** verification/tb_can_irq_router.sv ***
// Self-checking bench of the CAN interrupt router.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_regs.svh"
module tb_can_irq_router;
	logic        pclk, presetn, psel, penable, pwrite, pwm, compat;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, mtx, mrx;
	logic [3:0]  pstrb;
	logic        pready, pslverr, err, rxv, sv, l0, l1;
	logic [7:0]  ev;
	logic [4:0]  si, last_si;
	logic [1:0]  seen;
	int          mismatches, num_checks, nst, i;
	int          bits [8] = '{17, 16, 14, 13, 12, 10, 9, 8};

	can_irq_router i_can_irq_router (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .protected_write_mode(pwm),
		.reduced_compat_mode(compat), .timeout_event(ev[0]),
		.stamp_overflow_event(ev[1]), .abort_ack_event(ev[2]),
		.write_denied_event(ev[3]), .wakeup_event(ev[4]),
		.bus_off_event(ev[5]), .error_passive_event(ev[6]),
		.warning_level_event(ev[7]), .tx_done(mtx), .rx_valid(rxv),
		.rx_match(mrx), .rx_store_valid(sv), .rx_store_index(si),
		.irq_line_zero(l0), .irq_line_one(l1));
	irq_sink i_irq_sink (.pclk(pclk), .presetn(presetn),
		.irq_line_zero(l0), .irq_line_one(l1), .seen(seen));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (sv === 1'b1) begin
			last_si <= si;
			nst <= nst + 1;
		end
	end

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkr(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, 4'hF);
		chk(rd, exp);
	endtask

	task automatic chks(input logic [1:0] exp);
		idle(3);
		chk({30'h0000_0000, seen}, {30'h0000_0000, exp});
	endtask

	task automatic mset(input logic [31:0] d);
		wr(`OFS_GLOBAL_MASK, d);
	endtask

	task automatic rxmsg(input logic [31:0] m);
		@(posedge pclk);
		rxv <= 1'b1;
		mrx <= m;
		@(posedge pclk);
		rxv <= 1'b0;
		idle(6);
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		conclude();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, pwm, compat, rxv} = 6'h00;
		{paddr, pwdata, pstrb, ev, mtx, mrx} = '0;
		nst = 0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chkr(`OFS_MBOX_MASK, 32'h0000_0000);
		chkr(`OFS_MBOX_LINE, 32'h0000_0000);
		mset(32'hFFFF_FFFF);
		chkr(`OFS_GLOBAL_MASK, 32'h0000_0000);
		wr(`OFS_MBOX_MASK, 32'hFFFF_FFFF);
		chkr(`OFS_MBOX_MASK, 32'h0000_0000);
		pwm <= 1'b1;
		mset(32'hFFFF_FFFF);
		chkr(`OFS_GLOBAL_MASK, 32'h0003_7F07);
		apb(1'b0, 12'h020, 32'h0000_0000, 4'hF);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		apb(1'b1, `OFS_PROTECT, 32'hFFFF_FFFF, 4'h3);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		chkr(`OFS_PROTECT, 32'h0000_0000);
		$display("test registers done");
		for (i = 0; i < 8; i++) begin
			mset(32'h0000_0001 | (32'h0000_0001 << bits[i]));
			@(posedge pclk);
			ev <= 8'h01 << i;
			@(posedge pclk);
			ev <= 8'h00;
			chks(2'b01);
			mset(32'h0000_0003);
			chks(2'b00);
			mset(32'h0000_0006 | (32'h0000_0001 << bits[i]));
			chks(2'b10);
			mset(32'h0000_0005 | (32'h0000_0001 << bits[i]));
			chks(2'b00);
			mset(32'h0000_0002 | (32'h0000_0001 << bits[i]));
			chks(2'b00);
			wr(`OFS_SOURCES, 32'h0000_0001 << bits[i]);
		end
		$display("test global sources done");
		mset(32'h0000_0003);
		wr(`OFS_MBOX_LINE, 32'h0000_0020);
		wr(`OFS_MBOX_MASK, 32'h0010_00A0);
		@(posedge pclk);
		mtx <= 32'h0000_0020;
		@(posedge pclk);
		mtx <= 32'h0000_0000;
		chks(2'b10);
		chkr(`OFS_STATUS, 32'h0000_00A5);
		wr(`OFS_MBOX_MASK, 32'h0010_0080);
		chks(2'b00);
		wr(`OFS_PENDING, 32'h0000_0020);
		@(posedge pclk);
		mtx <= 32'h0010_0080;
		@(posedge pclk);
		mtx <= 32'h0000_0000;
		chks(2'b01);
		chkr(`OFS_STATUS, 32'h0000_0074);
		compat <= 1'b1;
		chkr(`OFS_STATUS, 32'h0000_0067);
		compat <= 1'b0;
		wr(`OFS_PENDING, 32'h0010_0080);
		wr(`OFS_MBOX_MASK, 32'h0000_0000);
		$display("test mailboxes done");
		mset(32'h0000_0801);
		rxmsg(32'h0000_0008);
		chk({27'h000_0000, last_si}, 32'h0000_0003);
		rxmsg(32'h0000_0008);
		chk({27'h000_0000, last_si}, 32'h0000_0003);
		chkr(`OFS_LOST, 32'h0000_0008);
		chks(2'b01);
		wr(`OFS_PENDING, 32'h0000_0008);
		chks(2'b00);
		wr(`OFS_LOST, 32'h0000_0008);
		wr(`OFS_PROTECT, 32'h0000_0008);
		chkr(`OFS_PROTECT, 32'h0000_0008);
		rxmsg(32'h0000_0008);
		rxmsg(32'h0000_000C);
		chk({27'h000_0000, last_si}, 32'h0000_0002);
		i = nst;
		rxmsg(32'h0000_0008);
		chk(nst - i, 32'h0000_0000);
		chkr(`OFS_LOST, 32'h0000_0000);
		$display("test receive overwrite done");
		conclude();
	end
endmodule // tb_can_irq_router
`default_nettype wire
